// ### verilog/rsse_defines.svh
`ifndef RSSE_DEFINES_SVH
`define RSSE_DEFINES_SVH

// clocks
`define RSSE_SYS_CLK_HZ     250000000
`define RSSE_BUS_CLK_HZ     32768
`define RSSE_BUS_DIV        (`RSSE_SYS_CLK_HZ / `RSSE_BUS_CLK_HZ)

// sampling
`define RSSE_SAMPLE_HZ      400
`define RSSE_MODULO_RESET   16'd81
`define RSSE_SCAN_CYCLES    9'd256
`define RSSE_ARRAY_DEPTH    256

// register offsets
`define RSSE_OFF_CTRL       12'h000
`define RSSE_OFF_MODULO     12'h004
`define RSSE_OFF_MUX_S0     12'h008
`define RSSE_OFF_MUX_S1     12'h00c
`define RSSE_OFF_MUX_OFF    12'h010
`define RSSE_OFF_STATUS     12'h014
`define RSSE_OFF_MASK       12'h018
`define RSSE_OFF_PROGRESS   12'h01c
`define RSSE_OFF_ARRAY      12'h400

// control fields
`define RSSE_CTRL_ENABLE    0
`define RSSE_CTRL_REARM     1

// status fields
`define RSSE_ST_WAKE        0
`define RSSE_ST_CAPTURE     1
`define RSSE_ST_WIDTH       2

// mux byte fields
`define RSSE_MUX_POS_LSB    0
`define RSSE_MUX_NEG_LSB    3
`define RSSE_MUX_SEL_W      3

// reset values of mux bytes
`define RSSE_MUX_S0_RESET   8'h08
`define RSSE_MUX_S1_RESET   8'h19
`define RSSE_MUX_OFF_RESET  8'h3f

`endif

// ### verilog/rsse_pkg.sv
package rsse_pkg;

  typedef logic [7:0]  rsse_byte_t;
  typedef logic [11:0] rsse_addr_t;
  typedef logic [31:0] rsse_word_t;

  typedef enum logic [1:0] {
    RSSE_IDLE,
    RSSE_POWERED,
    RSSE_MUX_OFF
  } rsse_phase_t;

  typedef struct packed {
    logic [12:0]  divCnt;
    logic         busTick;
    logic         enable;
    logic         armed;
    logic [15:0]  modulo;
    logic [15:0]  timerCnt;
    rsse_byte_t   muxCfg0;
    rsse_byte_t   muxCfg1;
    rsse_byte_t   muxOffCfg;
    rsse_byte_t   muxSetting;
    logic         compEnable;
    logic         supply;
    logic         sensorSel;
    rsse_phase_t  phase;
    logic [7:0]   wrPtr;
    logic [8:0]   cycles;
    logic [1:0]   status;
    logic [1:0]   mask;
    logic         irq;
    logic         wake;
    rsse_word_t   rdata;
  } rsse_state_t;

endpackage

// ### verilog/rsse_scan_engine.sv
// Operation
// - one supply pulse per sampling period
// - pulse lasts one bus clock, comparator on while the mux byte selects two different inputs
// - comparator sampled at end of pulse
// - period set by programmable modulo, overflow
// - modulo defaults to 400 Hz sampling
// - timer counts bus clock regardless of sleep
// - cycles alternate sensor 0 then 1
// - one transfer per trigger event
// - overflow copies sensor mux byte to mux while armed
// - comparator off when both inputs equal
// - supply channel drives sensor supply pin
// - compare event stores comparator status in array
// - results interleaved in one byte array
// - capture completion writes mux off byte
// - wake processor after 256 cycles
`include "rsse_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module rsse_scan_engine #(
  parameter int unsigned BUS_DIV = `RSSE_BUS_DIV
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // register port
  input  wire rsse_pkg::rsse_addr_t regAddr,
  input  wire rsse_pkg::rsse_word_t regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic [31:0]           regRdata,
  // sensors and comparator
  input  wire logic             compOut,
  output logic                  sensorSupply,
  output logic [7:0]            muxSetting,
  output logic                  compEnable,
  output logic                  sensorSel,
  // processor
  output logic                  wakeUp,
  output logic                  irq
);
  import rsse_pkg::*;

  rsse_state_t st;
  rsse_state_t next_st;
  rsse_byte_t  resultMem [`RSSE_ARRAY_DEPTH];
  logic        memWe;
  logic [1:0]  rstSync;
  logic        rstLocal_b;
  logic [1:0]  compSync;
  logic        compEvent;
  logic        overflowEvent;
  logic [1:0]  statusSet;

  function automatic logic muxValid(input rsse_byte_t m);
    muxValid = m[`RSSE_MUX_POS_LSB +: `RSSE_MUX_SEL_W] !=
               m[`RSSE_MUX_NEG_LSB +: `RSSE_MUX_SEL_W];
  endfunction

  // reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstLocal_b = rstSync[1];

  // comparator level from the analog side
  always_ff @(posedge clk or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      compSync <= 2'h0;
    end else begin
      compSync <= {compSync[0], compOut};
    end
  end

  always_comb begin
    next_st       = st;
    overflowEvent = 1'b0;
    compEvent     = 1'b0;
    memWe         = 1'b0;
    statusSet     = 2'h0;
    // bus clock enable from divider
    next_st.busTick = 1'b0;
    if (st.divCnt == 13'(BUS_DIV - 1)) begin
      next_st.divCnt  = 13'h0;
      next_st.busTick = 1'b1;
    end else begin
      next_st.divCnt = st.divCnt + 13'h1;
    end
    // sample timer on bus clock
    if (st.enable && st.busTick) begin
      if (st.timerCnt >= st.modulo - 16'h1) begin
        next_st.timerCnt = 16'h0;
        overflowEvent    = 1'b1;
      end else begin
        next_st.timerCnt = st.timerCnt + 16'h1;
      end
      // compare at one bus period after overflow
      compEvent = (st.phase == RSSE_POWERED);
    end
    if (!st.enable) begin
      next_st.timerCnt = 16'h0;
    end
    // supply pulse one bus period long
    if (overflowEvent) begin
      next_st.supply = 1'b1;
    end else if (st.enable && st.busTick && st.supply) begin
      // pulse ends on the next tick even when no transfer is armed
      next_st.supply = 1'b0;
    end
    unique case (st.phase)
      RSSE_IDLE: begin
        if (overflowEvent && st.armed) begin
          // mux-on transfer
          next_st.muxSetting = st.sensorSel ? st.muxCfg1 : st.muxCfg0;
          next_st.phase      = RSSE_POWERED;
        end
      end
      RSSE_POWERED: begin
        if (compEvent) begin
          memWe          = 1'b1;
          next_st.wrPtr  = st.wrPtr + 8'h1;
          statusSet[`RSSE_ST_CAPTURE] = 1'b1;
          next_st.phase  = RSSE_MUX_OFF;
        end
      end
      RSSE_MUX_OFF: begin
        // chained after capture
        next_st.muxSetting = st.muxOffCfg;
        next_st.sensorSel  = ~st.sensorSel;
        next_st.cycles     = st.cycles + 9'h1;
        next_st.phase      = RSSE_IDLE;
        if (st.cycles + 9'h1 == `RSSE_SCAN_CYCLES) begin
          next_st.armed = 1'b0;
          next_st.wake  = 1'b1;
          statusSet[`RSSE_ST_WAKE] = 1'b1;
        end
      end
    endcase
    next_st.compEnable = muxValid(next_st.muxSetting);
    // register writes
    if (regWr) begin
      unique case (regAddr)
        `RSSE_OFF_CTRL: begin
          next_st.enable = regWdata[`RSSE_CTRL_ENABLE];
          if (regWdata[`RSSE_CTRL_REARM]) begin
            next_st.armed     = 1'b1;
            next_st.wrPtr     = 8'h0;
            next_st.cycles    = 9'h0;
            next_st.wake      = 1'b0;
            next_st.sensorSel = 1'b0;
          end
        end
        `RSSE_OFF_MODULO:  next_st.modulo    = regWdata[15:0];
        `RSSE_OFF_MUX_S0:  next_st.muxCfg0   = regWdata[7:0];
        `RSSE_OFF_MUX_S1:  next_st.muxCfg1   = regWdata[7:0];
        `RSSE_OFF_MUX_OFF: next_st.muxOffCfg = regWdata[7:0];
        `RSSE_OFF_MASK:    next_st.mask      = regWdata[1:0];
        default: ;
      endcase
    end
    // reads
    next_st.rdata = 32'h0;
    if (regRd) begin
      if (regAddr[11:10] == 2'h1) begin
        next_st.rdata = {24'h0, resultMem[regAddr[9:2]]};
      end else begin
        unique case (regAddr)
          `RSSE_OFF_CTRL:     next_st.rdata = {30'h0, st.armed, st.enable};
          `RSSE_OFF_MODULO:   next_st.rdata = {16'h0, st.modulo};
          `RSSE_OFF_MUX_S0:   next_st.rdata = {24'h0, st.muxCfg0};
          `RSSE_OFF_MUX_S1:   next_st.rdata = {24'h0, st.muxCfg1};
          `RSSE_OFF_MUX_OFF:  next_st.rdata = {24'h0, st.muxOffCfg};
          `RSSE_OFF_STATUS:   next_st.rdata = {30'h0, st.status};
          `RSSE_OFF_MASK:     next_st.rdata = {30'h0, st.mask};
          `RSSE_OFF_PROGRESS: next_st.rdata = {st.sensorSel, 6'h0, st.cycles,
                                               8'h0, st.wrPtr};
          default: ;
        endcase
      end
    end
    // status read clears, new events win
    if (regRd && regAddr == `RSSE_OFF_STATUS) begin
      next_st.status = statusSet;
    end else begin
      next_st.status = st.status | statusSet;
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge clk or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      st            <= '0;
      st.modulo     <= `RSSE_MODULO_RESET;
      st.muxCfg0    <= `RSSE_MUX_S0_RESET;
      st.muxCfg1    <= `RSSE_MUX_S1_RESET;
      st.muxOffCfg  <= `RSSE_MUX_OFF_RESET;
      st.muxSetting <= `RSSE_MUX_OFF_RESET;
      st.phase      <= RSSE_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // result array, no reset needed
  always_ff @(posedge clk) begin
    if (memWe) begin
      resultMem[st.wrPtr] <= {7'h0, compSync[1]};
    end
  end

  assign regRdata     = st.rdata;
  assign sensorSupply = st.supply;
  assign muxSetting   = st.muxSetting;
  assign compEnable   = st.compEnable;
  assign sensorSel    = st.sensorSel;
  assign wakeUp       = st.wake;
  assign irq          = st.irq;

endmodule

`default_nettype wire

// ### tb/rsse_sensor_model.sv
`timescale 1ns/1ns
`default_nettype none
module rsse_sensor_model (
  // scan engine side
  input  wire logic       clk,
  input  wire logic       sensorSupply,
  input  wire logic [7:0] muxSetting,
  input  wire logic       compEnable,
  output logic            compOut
);
  logic junk = 1'b0;
  // unpowered or disabled comparator output is junk: keep it moving
  always @(posedge clk) junk <= ~junk;
  // sensor 0 reads high, sensor 1 low
  assign compOut = (sensorSupply && compEnable) ? ~muxSetting[0] : junk;
endmodule
`default_nettype wire

// ### tb/rsse_scan_props.sv
`timescale 1ns/1ns
`default_nettype none
module rsse_scan_props #(
  parameter int unsigned BUS_DIV = 8
) (
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire rsse_pkg::rsse_addr_t regAddr,
  input wire rsse_pkg::rsse_word_t regWdata,
  input wire logic                 regWr,
  input wire logic                 regRd,
  input wire logic [31:0]          regRdata,
  input wire logic                 compOut,
  input wire logic                 sensorSupply,
  input wire logic [7:0]           muxSetting,
  input wire logic                 compEnable,
  input wire logic                 sensorSel,
  input wire logic                 wakeUp,
  input wire logic                 irq
);
  logic [15:0] hiCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) hiCnt <= '0;
    else hiCnt <= sensorSupply ? hiCnt + 16'h1 : 16'h0;
  end
  chk_pulse_width: assert property ($fell(sensorSupply) |-> hiCnt == BUS_DIV)
    else $error("supply pulse width wrong");
  chk_comp_mux: assert property (compEnable == (muxSetting[2:0] != muxSetting[5:3]))
    else $error("comparator enable disagrees with mux");
  chk_on_at_pulse: assert property ($rose(compEnable) |-> $rose(sensorSupply))
    else $error("comparator on outside overflow");
  chk_comp_window: assert property (compEnable |-> sensorSupply || $past(sensorSupply))
    else $error("comparator on without supply");
  chk_off_after: assert property ($fell(sensorSupply) && compEnable |=> !compEnable)
    else $error("mux off late");
  chk_sel_toggle: assert property ($fell(compEnable) |-> sensorSel != $past(sensorSel))
    else $error("sensor select did not toggle");
  chk_sel_cause: assert property ($changed(sensorSel) |-> $fell(compEnable) || $past(regWr))
    else $error("sensor select changed alone");
  chk_wake_hold: assert property (wakeUp && !regWr |=> wakeUp)
    else $error("wake dropped");
  chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read cycle");
  cover property ($rose(wakeUp));
  cover property ($fell(compEnable));
  cover property ($rose(irq));
endmodule
bind rsse_scan_engine rsse_scan_props #(.BUS_DIV(BUS_DIV)) u_props (.clk(clk), .rst_b(rst_b),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .compOut(compOut), .sensorSupply(sensorSupply), .muxSetting(muxSetting),
  .compEnable(compEnable), .sensorSel(sensorSel), .wakeUp(wakeUp), .irq(irq));
`default_nettype wire

// ### tb/rotation_sensor_scan_engine_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rotation_sensor_scan_engine_tb;
  import rsse_pkg::*;
  localparam int DIV = 8;
  localparam int MOD = 4;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  rsse_addr_t regAddr = '0;
  rsse_word_t regWdata = '0;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic [31:0] regRdata;
  logic [7:0] muxSetting;
  logic       compOut, sensorSupply, compEnable, sensorSel, wakeUp, irq;
  int         err_count = 0;
  int         tests_run = 0;
  int         w;
  always #2 clk = ~clk;
  rsse_scan_engine #(.BUS_DIV(DIV)) DUT (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .compOut(compOut),
    .sensorSupply(sensorSupply), .muxSetting(muxSetting), .compEnable(compEnable),
    .sensorSel(sensorSel), .wakeUp(wakeUp), .irq(irq));
  rsse_sensor_model u_sens (.clk(clk), .sensorSupply(sensorSupply), .muxSetting(muxSetting),
    .compEnable(compEnable), .compOut(compOut));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input rsse_addr_t a, input rsse_word_t d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input rsse_addr_t a, input logic [31:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check(regRdata, exp);
  endtask
  // wait until supply (0) or wake (1) is seen high
  task automatic wait_hi(input int which, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk);
      #1;
      if ((which == 0 ? sensorSupply : wakeUp) === 1'b1) break;
    end
    if (i == lim) begin
      err_count++;
      end_of_test;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(12'h004, 32'd81);
    rd(12'h008, 32'h08);
    rd(12'h010, 32'h3f);
    rd(12'h020, 32'h0);
    check({muxSetting, 7'h0, compEnable}, {8'h3f, 8'h0});
    wr(12'h004, MOD);
    wr(12'h018, 32'h1);
    wr(12'h000, 32'h3);
    wait_hi(0, 200);
    check({muxSetting, 7'h0, sensorSel, 7'h0, compEnable}, 24'h080001);
    for (w = 1; w < 100 && sensorSupply === 1'b1; w++) begin
      @(posedge clk);
      #1;
    end
    check(w - 1, DIV);
    for (; w < 200 && sensorSupply !== 1'b1; w++) begin
      @(posedge clk);
      #1;
    end
    check(w - 1, DIV * MOD);
    check(muxSetting, 8'h19);
    wait_hi(1, 10000);
    rd(12'h01c, 32'h0100_0000);
    check(irq, 1'b1);
    rd(12'h014, 32'h3);
    for (w = 0; w < 256; w++) rd(12'h400 + 4 * w, {31'h0, ~w[0]});
    check(irq, 1'b0);
    wr(12'h000, 32'h3);
    rd(12'h01c, 32'h0);
    check(wakeUp, 1'b0);
    wr(12'h018, 32'h2);
    wait_hi(0, 200);
    repeat (DIV + 3) @(posedge clk);
    check(irq, 1'b1);
    rd(12'h014, 32'h2);
    rd(12'h01c, 32'h8001_0001);
    end_of_test;
  end
endmodule
`default_nettype wire
